// ==== hdl/sadc_pkg.sv ====
// Shared constants for the converter readout link and its two ends.
package sadc_pkg;
  localparam int RES_BITS = 18;
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_CONV_NS = 3000;
  localparam int CONV_CYC = T_CONV_NS / CLK_PERIOD_NS;
  localparam int T_CNVH_NS = 20;
  localparam int CNVH_CYC = (T_CNVH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_QUIET_NS = 20;
  localparam int QUIET_CYC = (T_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_SCK_CHAIN_PS = 13500;
  localparam int SCK_HALF_CYC = 4;
  localparam int SYNC_W = 4;
  // The enable bit of the pin synchroniser resets to its idle level, high.
  localparam logic [SYNC_W-1:0] SYNC_RST = 4'h4;
  localparam int CNT_W = 8;
  localparam logic [RES_BITS-1:0] CODE_RST = 18'h00000;
  typedef enum logic {SADC_NAP, SADC_CONV} sadc_dev_state_t;
  typedef enum logic [2:0] {SADC_H_IDLE, SADC_H_PULSE, SADC_H_WAIT, SADC_H_LEAD,
                            SADC_H_SHIFT, SADC_H_DONE} sadc_host_state_t;
endpackage : sadc_pkg

// ==== hdl/sadc_link_if.sv ====
// Pin-level link between the converter end and the serial master end.
`timescale 1ns/10ps
`default_nettype none
interface sadc_link_if;
  logic convert_start;
  logic busy;
  logic sck;
  logic read_enable_or_serial_in;
  logic sdo;
  logic sdo_oe_n;
  wire sdo_bus;
  // A released pin shows the inverse bit, so that a capture while released fails.
  assign sdo_bus = sdo_oe_n ? ~sdo : sdo;
  modport dev (input convert_start, input sck, input read_enable_or_serial_in,
               output busy, output sdo, output sdo_oe_n);
  modport host (output convert_start, output sck, output read_enable_or_serial_in,
                input busy, input sdo_bus);
endinterface : sadc_link_if
`default_nettype wire

// ==== hdl/sadc_device.sv ====
// Converter end: conversion control, busy flag and serial result shifter.
//
// Notes on behaviour
// R1 - Rising convert edge wakes and starts conversion.
// R2 - Busy high during conversion, low when done.
// R3 - Mode low: shared pin enables output drive.
// R4 - Mode high: shared pin is chain input.
// R5 - Shift out MSB first on serial clock rises.
// R6 - Result is two's complement.
// R7 - Host keeps serial clock quiet after convert.
// R8 - Host holds convert high, low 20 ns.
// R9 - Output drives/releases promptly after enable changes.
// R10 - Host serial clock up to 100 MHz.
// R11 - Chain mode clock period at least 13.5 ns.
// R12 - Chain input sampled on serial clock rises.
// R13 - First result bit valid when busy falls.
// R14 - Conversion end prepares 18-bit output code.
// R15 - Host waits busy fall, one word each.
// R16 - Chain data follows own result, one word later.
`timescale 1ns/10ps
`default_nettype none
module sadc_device
#(
  parameter int RES = sadc_pkg::RES_BITS,
  parameter int CONV_CYC = sadc_pkg::CONV_CYC
)
(
  // Clock, reset and enable
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // Link pins
  sadc_link_if.dev link,
  // Mode pin and analog core code
  input wire logic chain_mode_in,
  input wire logic [RES-1:0] sample_code_in,
  // Status
  output logic napping_out,
  output logic start_ignored_out
);
  import sadc_pkg::*;

  logic [SYNC_W-1:0] meta_reg;
  logic [SYNC_W-1:0] sync_reg;
  logic prev_cnv_reg;
  logic prev_sck_reg;
  logic cnv_s;
  logic sck_s;
  logic sdi_s;
  logic chain_s;
  logic cnv_rise;
  logic sck_rise;
  logic conv_end;
  sadc_dev_state_t state_reg;
  logic [CNT_W-1:0] conv_cnt_reg;
  logic [RES-1:0] code_reg;
  logic [RES-1:0] shift_reg;
  logic [RES-1:0] shift_next;
  logic busy_reg;
  logic oe_n_reg;
  logic shift_en;

  // All pins come from outside this clock domain, so each passes two flops.
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      // A zero on the enable bit would turn the driver on right after reset.
      meta_reg <= SYNC_RST;
      sync_reg <= SYNC_RST;
    end
    else if (ce_in)
    begin
      meta_reg <= {chain_mode_in, link.read_enable_or_serial_in,
                   link.sck, link.convert_start};
      sync_reg <= meta_reg;
    end
  end

  assign cnv_s = sync_reg[0];
  assign sck_s = sync_reg[1];
  assign sdi_s = sync_reg[2];
  assign chain_s = sync_reg[3];

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      prev_cnv_reg <= 1'b0;
      prev_sck_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      prev_cnv_reg <= cnv_s;
      prev_sck_reg <= sck_s;
    end
  end

  assign cnv_rise = cnv_s & ~prev_cnv_reg;
  assign sck_rise = sck_s & ~prev_sck_reg;
  assign conv_end = (state_reg == SADC_CONV) && (conv_cnt_reg == CNT_W'(CONV_CYC - 1));

  // Conversion sequencer. The converter naps between conversions and only an
  // edge on the convert pin wakes it; a level left high does nothing more.
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_reg <= SADC_NAP;
      conv_cnt_reg <= '0;
    end
    else if (ce_in)
    begin
      case (state_reg)
        SADC_NAP:
        begin
          conv_cnt_reg <= '0;
          if (cnv_rise)
          begin
            state_reg <= SADC_CONV; // R1
          end
        end
        SADC_CONV:
        begin
          if (conv_end)
          begin
            state_reg <= SADC_NAP;
            conv_cnt_reg <= '0;
          end
          else
          begin
            conv_cnt_reg <= conv_cnt_reg + CNT_W'(1);
          end
        end
        default:
        begin
          state_reg <= SADC_NAP;
          conv_cnt_reg <= '0;
        end
      endcase
    end
  end

  // The input is held at the convert edge, as the sampling switch would.
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      code_reg <= CODE_RST;
    end
    else if (ce_in && cnv_rise && state_reg == SADC_NAP)
    begin
      code_reg <= sample_code_in; // R6
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      busy_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      if (state_reg == SADC_NAP && cnv_rise)
      begin
        busy_reg <= 1'b1; // R2
      end
      else if (conv_end)
      begin
        busy_reg <= 1'b0; // R2
      end
    end
  end

  // A second convert edge inside a conversion cannot restart it; it is
  // flagged until the next accepted start so the user can see the overrun.
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      start_ignored_out <= 1'b0;
    end
    else if (ce_in && cnv_rise)
    begin
      start_ignored_out <= (state_reg == SADC_CONV);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      napping_out <= 1'b1;
    end
    else if (ce_in)
    begin
      napping_out <= (state_reg == SADC_NAP) && !(cnv_rise);
    end
  end

  // In normal mode the shared pin, active low, gates the output driver; in
  // chain mode the pin is data and the output always drives.
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      oe_n_reg <= 1'b1;
    end
    else if (ce_in)
    begin
      oe_n_reg <= chain_s ? 1'b0 : sdi_s; // R3 R4 R9
    end
  end

  // Shifting happens only outside a conversion, and in normal mode only
  // while the output is enabled.
  assign shift_en = sck_rise && !busy_reg && (chain_s || !sdi_s); // R5

  // The chain input enters at the low end, so once this word has gone out
  // the upstream bits follow exactly one word later.
  always_comb
  begin
    shift_next = {shift_reg[RES-2:0], chain_s ? sdi_s : 1'b0}; // R12 R16
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      shift_reg <= CODE_RST;
    end
    else if (ce_in)
    begin
      if (conv_end)
      begin
        shift_reg <= code_reg; // R14 R13
      end
      else if (shift_en)
      begin
        shift_reg <= shift_next; // R5
      end
    end
  end

  // The top bit of the shifter is the pin, so the MSB is already valid in
  // the cycle busy falls.
  assign link.sdo = shift_reg[RES-1]; // R13
  assign link.sdo_oe_n = oe_n_reg;
  assign link.busy = busy_reg;
endmodule : sadc_device
`default_nettype wire

// ==== hdl/sadc_host.sv ====
// Serial master end: starts conversions and clocks out the result words.
`timescale 1ns/10ps
`default_nettype none
module sadc_host
#(
  parameter int RES = sadc_pkg::RES_BITS,
  parameter int NUM_DEV = 1,
  parameter int SCK_HALF = sadc_pkg::SCK_HALF_CYC
)
(
  // Clock, reset and enable
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // Link pins
  sadc_link_if.host link,
  // User side
  input wire logic start_in,
  input wire logic chain_mode_in,
  output logic [RES*NUM_DEV-1:0] data_out,
  output logic data_valid_out,
  output logic idle_out
);
  import sadc_pkg::*;

  localparam int BITS = RES * NUM_DEV;
  logic [1:0] meta_reg;
  logic [1:0] sync_reg;
  sadc_host_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] bit_reg;
  logic cnv_reg;
  logic sck_reg;
  logic rdl_reg;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else if (ce_in)
    begin
      meta_reg <= {link.sdo_bus, link.busy};
      sync_reg <= meta_reg;
    end
  end

  // Convert stays high until busy is seen, which is longer than the least
  // high time; the serial clock stays idle through the whole conversion.
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_reg <= SADC_H_IDLE;
      cnt_reg <= '0;
      bit_reg <= '0;
      cnv_reg <= 1'b0;
      sck_reg <= 1'b0;
      rdl_reg <= 1'b1;
      data_out <= '0;
      data_valid_out <= 1'b0;
      idle_out <= 1'b1;
    end
    else if (ce_in)
    begin
      data_valid_out <= 1'b0;
      case (state_reg)
        SADC_H_IDLE:
        begin
          rdl_reg <= !chain_mode_in;
          cnt_reg <= '0;
          if (start_in)
          begin
            cnv_reg <= 1'b1; // R8
            idle_out <= 1'b0;
            state_reg <= SADC_H_PULSE;
          end
        end
        SADC_H_PULSE:
        begin
          cnt_reg <= cnt_reg + CNT_W'(1);
          if (sync_reg[0] && cnt_reg >= CNT_W'(CNVH_CYC + QUIET_CYC))
          begin
            cnv_reg <= 1'b0; // R8 R7
            state_reg <= SADC_H_WAIT;
          end
        end
        SADC_H_WAIT:
        begin
          cnt_reg <= '0;
          if (!sync_reg[0])
          begin
            rdl_reg <= 1'b0; // R15
            state_reg <= SADC_H_LEAD;
          end
        end
        SADC_H_LEAD:
        begin
          // Leaves time for the driver to turn on and pass the sync flops.
          cnt_reg <= cnt_reg + CNT_W'(1);
          if (cnt_reg == CNT_W'(2 * SCK_HALF - 1))
          begin
            cnt_reg <= '0;
            bit_reg <= '0;
            sck_reg <= 1'b1;
            data_out <= {data_out[BITS-2:0], sync_reg[1]};
            state_reg <= SADC_H_SHIFT;
          end
        end
        SADC_H_SHIFT:
        begin
          cnt_reg <= cnt_reg + CNT_W'(1);
          if (cnt_reg == CNT_W'(SCK_HALF - 1))
          begin
            cnt_reg <= '0;
            if (sck_reg)
            begin
              sck_reg <= 1'b0;
              if (bit_reg == CNT_W'(BITS - 1))
              begin
                state_reg <= SADC_H_DONE; // R15
              end
            end
            else
            begin
              sck_reg <= 1'b1; // R10 R11
              bit_reg <= bit_reg + CNT_W'(1);
              data_out <= {data_out[BITS-2:0], sync_reg[1]};
            end
          end
        end
        SADC_H_DONE:
        begin
          rdl_reg <= !chain_mode_in;
          data_valid_out <= 1'b1;
          idle_out <= 1'b1;
          state_reg <= SADC_H_IDLE;
        end
        default:
        begin
          state_reg <= SADC_H_IDLE;
        end
      endcase
    end
  end

  assign link.convert_start = cnv_reg;
  assign link.sck = sck_reg;
  assign link.read_enable_or_serial_in = rdl_reg;
endmodule : sadc_host
`default_nettype wire

// ==== sim/sadc_checker.sv ====
// Assertions on the pins between the converter end and the serial master.
`timescale 1ns/10ps
`default_nettype none
module sadc_checker
#(
  parameter int CONV_CYC = sadc_pkg::CONV_CYC
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Mode and code
  input wire logic chain_mode_in,
  input wire logic [sadc_pkg::RES_BITS-1:0] sample_code_in,
  // Link pins
  input wire logic convert_start,
  input wire logic busy,
  input wire logic sck,
  input wire logic read_enable_or_serial_in,
  input wire logic sdo,
  input wire logic sdo_oe_n
);
  import sadc_pkg::*;
  logic [CNT_W-1:0] busy_cnt_reg;
  // A counter keeps the long conversion span out of the property unrolling.
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      busy_cnt_reg <= '0;
    else
      busy_cnt_reg <= busy ? busy_cnt_reg + 8'h01 : '0;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  property p_conv_start;
    $rose(convert_start) && !busy |-> ##3 $rose(busy);
  endproperty
  a_conv_start: assert property (p_conv_start) else $error("busy late");
  property p_conv_len;
    $fell(busy) |-> busy_cnt_reg == CNT_W'(CONV_CYC);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("busy length");
  property p_first_bit;
    $fell(busy) |-> sdo == sample_code_in[RES_BITS-1];
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first bit");
  property p_shift;
    $changed(sdo) |-> $fell(busy) || $rose(busy) || ($past(sck, 3) && !$past(sck, 4));
  endproperty
  a_shift: assert property (p_shift) else $error("sdo moved");
  property p_oe_on;
    $fell(read_enable_or_serial_in) && !chain_mode_in |-> ##3 !sdo_oe_n;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("no drive");
  property p_oe_off;
    $rose(read_enable_or_serial_in) && !chain_mode_in && !$past(chain_mode_in, 4)
      |-> ##3 sdo_oe_n;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("no release");
  property p_busy_quiet;
    busy |-> !$rose(sck);
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("sck in busy");
  property p_cnv_high;
    $rose(convert_start) |-> !sck && convert_start ##1 convert_start;
  endproperty
  a_cnv_high: assert property (p_cnv_high) else $error("convert short");
  property p_sck_high;
    $rose(sck) |-> sck[*3];
  endproperty
  a_sck_high: assert property (p_sck_high) else $error("sck high");
  property p_sck_low;
    $fell(sck) |-> !sck[*3];
  endproperty
  a_sck_low: assert property (p_sck_low) else $error("sck low");
  property p_rdl_shift;
    sck && !chain_mode_in |-> !read_enable_or_serial_in;
  endproperty
  a_rdl_shift: assert property (p_rdl_shift) else $error("rdl high");
  c_conv: cover property ($fell(busy));
  c_chain: cover property (chain_mode_in && $rose(sck));
  c_oe: cover property ($fell(sdo_oe_n));
endmodule : sadc_checker
`default_nettype wire

// ==== sim/test_sar_adc_serial_readout.sv ====
// Bench that joins both link ends and checks whole result words.
`timescale 1ns/10ps
`default_nettype none
module test_sar_adc_serial_readout;
  import sadc_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic start = 1'b0;
  logic chain = 1'b0;
  logic chain_b = 1'b0;
  logic [RES_BITS-1:0] code = 18'h00000;
  logic [RES_BITS-1:0] codes [5] = '{18'h20000, 18'h1ffff, 18'h3ffff, 18'h00001, 18'h2aaaa};
  logic [2*RES_BITS-1:0] data;
  logic valid;
  logic idle;
  logic napping;
  logic ignored;
  int n;
  int num_errors = 0;
  int samples_checked = 0;
  sadc_link_if link ();
  sadc_link_if link_b ();
  always #12.5 clk_in = ~clk_in;
  sadc_device i_sadc_device (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(1'b1), .link(link),
    .chain_mode_in(chain), .sample_code_in(code), .napping_out(), .start_ignored_out());
  sadc_host #(.NUM_DEV(2)) i_sadc_host (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(1'b1),
    .link(link), .start_in(start), .chain_mode_in(chain), .data_out(data),
    .data_valid_out(valid), .idle_out(idle));
  // The second converter faces the bench so that misuse can be provoked.
  sadc_device i_sadc_device_b (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(1'b1),
    .link(link_b), .chain_mode_in(chain_b), .sample_code_in(code), .napping_out(napping),
    .start_ignored_out(ignored));
  sadc_checker i_sadc_checker (.clk_in(clk_in), .rst_b_in(rst_b_in), .chain_mode_in(chain),
    .sample_code_in(code), .convert_start(link.convert_start), .busy(link.busy),
    .sck(link.sck), .read_enable_or_serial_in(link.read_enable_or_serial_in),
    .sdo(link.sdo), .sdo_oe_n(link.sdo_oe_n));
  task check(input logic [2*RES_BITS-1:0] seen, input logic [2*RES_BITS-1:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : check
  task end_of_test;
    if (num_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  task xfer(input logic mode, input logic [RES_BITS-1:0] value);
    @(posedge clk_in);
    chain <= mode;
    code <= value;
    repeat (4) @(posedge clk_in);
    start <= 1'b1;
    @(posedge clk_in);
    start <= 1'b0;
    n = 0;
    while (valid !== 1'b1 && n < 2000)
    begin
      @(posedge clk_in);
      n++;
    end
    check(n < 2000, 1'b1);
    // The far word is zero: in normal mode the device shifts in zeros, in chain mode the master holds the chain input low.
    check(data, {value, 18'h00000});
    check(idle, 1'b1);
  endtask : xfer
  task pulse_b;
    link_b.sck <= 1'b1;
    repeat (4) @(posedge clk_in);
    link_b.sck <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask : pulse_b
  initial
  begin
    link_b.convert_start = 1'b0;
    link_b.sck = 1'b0;
    link_b.read_enable_or_serial_in = 1'b1;
    repeat (10) @(posedge clk_in);
    rst_b_in <= 1'b1;
    foreach (codes[i])
    begin
      xfer(1'b0, codes[i]);
      xfer(1'b1, codes[i]);
    end
    code <= 18'h2d2d2;
    @(posedge clk_in);
    check(napping, 1'b1);
    link_b.convert_start <= 1'b1;
    repeat (2) @(posedge clk_in);
    link_b.convert_start <= 1'b0;
    repeat (4) @(posedge clk_in);
    check(link_b.busy, 1'b1);
    check(napping, 1'b0);
    link_b.convert_start <= 1'b1;
    repeat (2) @(posedge clk_in);
    link_b.convert_start <= 1'b0;
    repeat (5) @(posedge clk_in);
    check(ignored, 1'b1);
    n = 0;
    while (link_b.busy === 1'b1 && n < 300)
    begin
      @(posedge clk_in);
      n++;
    end
    check(n < 300, 1'b1);
    // The nap flag follows the state one cycle after busy falls.
    @(posedge clk_in);
    check(napping, 1'b1);
    check(link_b.sdo, 1'b1);
    // Chain mode with the input held high: the far bits must follow the own word.
    chain_b <= 1'b1;
    link_b.read_enable_or_serial_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    repeat (17) pulse_b;
    check(link_b.sdo, 1'b0);
    pulse_b;
    check(link_b.sdo, 1'b1);
    end_of_test;
  end
  initial
  begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    end_of_test;
  end
endmodule : test_sar_adc_serial_readout
`default_nettype wire
